// File: inc/iml_pkg.sv
// Constants shared by the move, load and store executor
package iml_pkg;
  // Register window: 32 words reached over APB and by own-space moves
  localparam int         REG_WORDS   = 32;
  localparam logic [7:0] OFF_IP      = 8'h00;
  localparam logic [7:0] OFF_DSB     = 8'h04;
  localparam logic [7:0] OFF_OPD     = 8'h08;
  localparam logic [7:0] OFF_CMD     = 8'h0C;
  localparam logic [7:0] OFF_DMA_MODE_REGISTER   = 8'h10;
  localparam logic [7:0] OFF_DMA_CONTROL_REGISTER   = 8'h14;
  localparam logic [7:0] OFF_STAT    = 8'h18;
  localparam logic [7:0] OFF_FBR     = 8'h1C;
  localparam logic [7:0] OFF_BASE    = 8'h20;
  localparam logic [7:0] OFF_LIMIT   = 8'h80;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [1:0]  RST_IDX    = 2'h0;
  localparam int          OWN_LSB    = 7;
  // Register bit positions
  localparam int DMA_MODE_REGISTER_SRC_IO = 5;
  localparam int DMA_MODE_REGISTER_DST_IO = 4;
  localparam int DMA_CONTROL_REGISTER_PF_EN  = 5;
  localparam int STAT_ILL     = 0;
  localparam int STAT_RUN     = 1;
  // Instruction fields
  localparam logic [2:0] TYPE_MOVE    = 3'h6;
  localparam logic [2:0] TYPE_LS      = 3'h7;
  localparam logic [4:0] TYPE_JUMP    = 5'h10;
  localparam logic [1:0] TYPE_XFER    = 2'h2;
  localparam int         TC_POL       = 19;
  localparam int         TC_DCMP      = 18;
  localparam int         TC_PCMP      = 17;
  localparam int         MM_NOFLUSH   = 24;
  localparam int         LS_REL       = 28;
  localparam int         LS_NOFLUSH   = 25;
  localparam int         LS_LOAD      = 24;
  localparam logic [31:0] IP_STEP     = 32'h0000_0004;
  typedef enum {
    S_IDLE, S_FETCH, S_EXEC, S_MVRD, S_MVWR, S_LSMEM
  } iml_state_e;
endpackage

// File: hdl/iml_move_load_store.sv
// Executor for jump compare, memory move, load and store instructions
//
// Overview of operation
// - Set mask bits drop the matching first-byte-received bits from compare.
// - Low eight bits are the value compared with first-byte-received.
// - Taken jump fetches at second word target; pointer becomes target plus 4.
// - Mode bits 5 and 4 pick I/O or memory for source, destination.
// - Move byte count is the low 24 bits of the first word.
// - Move with differing low two address bits raises illegal-instruction.
// - Move loops read then write until count is zero, then fetches.
// - Nonzero bits 28 to 25 of a move raise illegal-instruction.
// - With prefetch on, move flushes prefetch unless bit 24 is set.
// - Own-space move address uses its low seven bits to pick a register.
// - First-byte-received is unwritable by host, move and load; store reads it.
// - Move source is word two, destination word three; base stays intact.
// - Load and store are two words; bit 28 picks absolute or offset.
// - Relative address is base register plus signed 24-bit offset.
// - Load/store to own registers runs the cycle, loads no data, then illegal.
// - Load uses source space bit, store destination bit; I/O uses I/O cycles.
// - First word bits 31 to 29 equal to 111 mean load or store.
// - Bit 24 set means load into a register, clear means store.
// - Register address is bits 22 to 16, byte count bits 2 to 0.
// - With prefetch on, store flushes unless bit 25; loads ignore bit 25.
// - Polarity bit picks jump on true or false; both compares must agree.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module iml_move_load_store
  import iml_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             memReq,
  output logic      [31:0] memAddr,
  output logic             memWe,
  output logic             memIo,
  output logic      [3:0]  memBe,
  output logic      [31:0] memWdata,
  input  wire logic [31:0] memRdata,
  input  wire logic        memAck,
  input  wire logic        fbrLoad,
  input  wire logic [7:0]  fbrData,
  input  wire logic        phaseMatch,
  output logic             prefetchFlush,
  output logic             illegalInstr,
  output logic             running
);

  function automatic logic [4:0] wordIdx(input logic [7:0] off);
    return off[6:2];
  endfunction

  function automatic logic [3:0] beMask(input logic [1:0] off,
                                        input logic [2:0] n);
    logic [2:0] k;
    logic [7:0] m;
    k = (n > 3'd4) ? 3'd4 : n;
    m = {4'h0, 4'hF >> (3'd4 - k)};
    m = m << off;
    return m[3:0];
  endfunction

  function automatic logic [2:0] stepBytes(input logic [1:0]  off,
                                           input logic [23:0] cnt);
    logic [2:0] avail;
    avail = 3'd4 - {1'b0, off};
    return (cnt < {21'h0, avail}) ? cnt[2:0] : avail;
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] val,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction

  // APB slave, one wait state on every access
  logic        pready_r;
  logic        pready_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        apbWrEn;
  logic        apbBad;

  logic [31:0] regs_r [REG_WORDS];
  logic [31:0] regsNxt [REG_WORDS];
  logic [31:0] statWord;

  assign apbBad  = (paddr >= OFF_LIMIT);
  assign apbWrEn = psel & penable & pwrite & pready_r & ~apbBad;

  always_comb begin
    pready_nxt  = 1'b0;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && penable && !pready_r) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = apbBad;
      if (apbBad || pwrite) begin
        prdata_nxt = RST_WORD;
      end else if (wordIdx(paddr) == wordIdx(OFF_STAT)) begin
        prdata_nxt = statWord;
      end else begin
        prdata_nxt = regs_r[wordIdx(paddr)];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      prdata_r  <= RST_WORD;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Core sequencer
  iml_state_e  state_r;
  iml_state_e  state_nxt;
  logic [1:0]  fetchIdx_r;
  logic [1:0]  fetchIdx_nxt;
  logic [31:0] dst_r;
  logic [31:0] dst_nxt;
  logic [31:0] lsAddr_r;
  logic [31:0] lsAddr_nxt;
  logic [31:0] buf_r;
  logic [31:0] buf_nxt;
  logic        memReq_r;
  logic        memReq_nxt;
  logic [31:0] memAddr_r;
  logic [31:0] memAddr_nxt;
  logic        memWe_r;
  logic        memWe_nxt;
  logic        memIo_r;
  logic        memIo_nxt;
  logic [3:0]  memBe_r;
  logic [3:0]  memBe_nxt;
  logic [31:0] memWdata_r;
  logic [31:0] memWdata_nxt;
  logic        flush_r;
  logic        flush_nxt;
  logic        ill_r;
  logic        ill_nxt;
  logic        run_r;

  logic [31:0] ip;
  logic [31:0] dsb;
  logic [31:0] opd;
  logic [31:0] cmd;
  logic [7:0]  fbr;
  logic [4:0]  regIdx;
  logic [2:0]  mvStep;
  logic [3:0]  mvBe;
  logic        pfEn;
  logic        dataEq;
  logic        allTrue;
  logic        allFalse;
  logic        jumpTaken;
  logic [31:0] relAddr;

  assign ip       = regs_r[wordIdx(OFF_IP)];
  assign dsb      = regs_r[wordIdx(OFF_DSB)];
  assign opd      = regs_r[wordIdx(OFF_OPD)];
  assign cmd      = regs_r[wordIdx(OFF_CMD)];
  assign fbr      = regs_r[wordIdx(OFF_FBR)][7:0];
  assign pfEn     = regs_r[wordIdx(OFF_DMA_CONTROL_REGISTER)][DMA_CONTROL_REGISTER_PF_EN];
  assign regIdx   = cmd[22:18];
  assign statWord = {30'h0, run_r, ill_r};
  assign mvStep   = stepBytes(opd[1:0], cmd[23:0]);
  assign mvBe     = beMask(opd[1:0], mvStep);
  assign dataEq   = ((fbr ^ cmd[7:0]) & ~cmd[15:8]) == 8'h00;
  assign allTrue  = (!cmd[TC_DCMP] || dataEq) &&
                    (!cmd[TC_PCMP] || phaseMatch);
  assign allFalse = (!cmd[TC_DCMP] || !dataEq) &&
                    (!cmd[TC_PCMP] || !phaseMatch);
  assign jumpTaken = cmd[TC_POL] ? allTrue : allFalse;
  assign relAddr  = dsb + {{8{opd[23]}}, opd[23:0]};

  function automatic logic ownHit(input logic [31:0] a,
                                  input logic [31:0] base);
    return a[31:OWN_LSB] == base[31:OWN_LSB];
  endfunction

  // First-byte-received lane stays untouched by host, move and load writes
  function automatic logic [3:0] lanesFor(input logic [4:0] idx,
                                          input logic [3:0] be);
    if (idx == wordIdx(OFF_FBR)) begin
      return be & 4'hE;
    end
    if (idx == wordIdx(OFF_STAT)) begin
      return 4'h0;
    end
    return be;
  endfunction

  always_comb begin
    regsNxt      = regs_r;
    state_nxt    = state_r;
    fetchIdx_nxt = fetchIdx_r;
    dst_nxt      = dst_r;
    lsAddr_nxt   = lsAddr_r;
    buf_nxt      = buf_r;
    memReq_nxt   = memReq_r;
    memAddr_nxt  = memAddr_r;
    memWe_nxt    = memWe_r;
    memIo_nxt    = memIo_r;
    memBe_nxt    = memBe_r;
    memWdata_nxt = memWdata_r;
    flush_nxt    = 1'b0;
    ill_nxt      = ill_r;
    if (fbrLoad) begin
      regsNxt[wordIdx(OFF_FBR)][7:0] = fbrData;
    end
    if (apbWrEn) begin
      regsNxt[wordIdx(paddr)] = mergeBytes(regs_r[wordIdx(paddr)], pwdata,
                                  lanesFor(wordIdx(paddr), 4'hF));
      if (wordIdx(paddr) == wordIdx(OFF_STAT) && pwdata[STAT_ILL]) begin
        ill_nxt = 1'b0;
      end
      if (wordIdx(paddr) == wordIdx(OFF_IP)) begin
        state_nxt    = S_FETCH;
        fetchIdx_nxt = RST_IDX;
      end
    end
    case (state_r)
      S_IDLE: begin
      end
      S_FETCH: begin
        if (!memReq_r) begin
          memReq_nxt  = 1'b1;
          memAddr_nxt = ip;
          memWe_nxt   = 1'b0;
          memIo_nxt   = 1'b0;
          memBe_nxt   = 4'hF;
        end else if (memAck) begin
          memReq_nxt = 1'b0;
          regsNxt[wordIdx(OFF_IP)] = ip + IP_STEP;
          case (fetchIdx_r)
            2'd0:    regsNxt[wordIdx(OFF_CMD)] = memRdata;
            2'd1:    regsNxt[wordIdx(OFF_OPD)] = memRdata;
            default: dst_nxt = memRdata;
          endcase
          if (fetchIdx_r == 2'd2 ||
              (fetchIdx_r == 2'd1 && cmd[31:29] != TYPE_MOVE)) begin
            state_nxt = S_EXEC;
          end else begin
            fetchIdx_nxt = fetchIdx_r + 2'd1;
          end
        end
      end
      S_EXEC: begin
        fetchIdx_nxt = RST_IDX;
        state_nxt    = S_FETCH;
        if (cmd[31:29] == TYPE_MOVE) begin
          if (cmd[28:25] != 4'h0 || opd[1:0] != dst_r[1:0]) begin
            ill_nxt   = 1'b1;
            state_nxt = S_IDLE;
          end else begin
            flush_nxt = pfEn && !cmd[MM_NOFLUSH];
            if (cmd[23:0] != 24'h0) begin
              state_nxt = S_MVRD;
            end
          end
        end else if (cmd[31:29] == TYPE_LS) begin
          lsAddr_nxt = cmd[LS_REL] ? relAddr : opd;
          if (cmd[LS_LOAD] && regIdx == wordIdx(OFF_FBR)) begin
            ill_nxt   = 1'b1;
            state_nxt = S_IDLE;
          end else begin
            flush_nxt = pfEn && !cmd[LS_LOAD] &&
                        !cmd[LS_NOFLUSH];
            state_nxt = S_LSMEM;
          end
        end else if (cmd[31:27] == TYPE_JUMP) begin
          if (jumpTaken) begin
            regsNxt[wordIdx(OFF_IP)] = opd;
          end
        end else begin
          ill_nxt   = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_MVRD: begin
        if (ownHit(opd, regs_r[wordIdx(OFF_BASE)])) begin
          buf_nxt   = (opd[6:2] == wordIdx(OFF_STAT)) ? statWord
                                                      : regs_r[opd[6:2]];
          state_nxt = S_MVWR;
        end else if (!memReq_r) begin
          memReq_nxt  = 1'b1;
          memAddr_nxt = opd;
          memWe_nxt   = 1'b0;
          memIo_nxt   = regs_r[wordIdx(OFF_DMA_MODE_REGISTER)][DMA_MODE_REGISTER_SRC_IO];
          memBe_nxt   = mvBe;
        end else if (memAck) begin
          memReq_nxt = 1'b0;
          buf_nxt    = memRdata;
          state_nxt  = S_MVWR;
        end
      end
      S_MVWR: begin
        if (ownHit(dst_r, regs_r[wordIdx(OFF_BASE)]) ||
            (memReq_r && memAck)) begin
          if (ownHit(dst_r, regs_r[wordIdx(OFF_BASE)])) begin
            regsNxt[dst_r[6:2]] = mergeBytes(regs_r[dst_r[6:2]], buf_r,
                                    lanesFor(dst_r[6:2], mvBe));
          end
          memReq_nxt = 1'b0;
          regsNxt[wordIdx(OFF_OPD)] = opd + {29'h0, mvStep};
          dst_nxt = dst_r + {29'h0, mvStep};
          regsNxt[wordIdx(OFF_CMD)][23:0] =
            cmd[23:0] - {21'h0, mvStep};
          state_nxt = (cmd[23:0] == {21'h0, mvStep}) ? S_FETCH : S_MVRD;
        end else if (!memReq_r) begin
          memReq_nxt   = 1'b1;
          memAddr_nxt  = dst_r;
          memWe_nxt    = 1'b1;
          memIo_nxt    = regs_r[wordIdx(OFF_DMA_MODE_REGISTER)][DMA_MODE_REGISTER_DST_IO];
          memBe_nxt    = mvBe;
          memWdata_nxt = buf_r;
        end
      end
      S_LSMEM: begin
        if (!memReq_r) begin
          memReq_nxt   = 1'b1;
          memAddr_nxt  = lsAddr_r;
          memWe_nxt    = !cmd[LS_LOAD];
          memIo_nxt    = cmd[LS_LOAD]
                         ? regs_r[wordIdx(OFF_DMA_MODE_REGISTER)][DMA_MODE_REGISTER_SRC_IO]
                         : regs_r[wordIdx(OFF_DMA_MODE_REGISTER)][DMA_MODE_REGISTER_DST_IO];
          memBe_nxt    = beMask(lsAddr_r[1:0], cmd[2:0]);
          memWdata_nxt = (regIdx == wordIdx(OFF_STAT)) ? statWord
                                                       : regs_r[regIdx];
        end else if (memAck) begin
          memReq_nxt = 1'b0;
          if (ownHit(lsAddr_r, regs_r[wordIdx(OFF_BASE)])) begin
            ill_nxt   = 1'b1;
            state_nxt = S_IDLE;
          end else begin
            if (cmd[LS_LOAD]) begin
              regsNxt[regIdx] = mergeBytes(regs_r[regIdx], memRdata,
                                  lanesFor(regIdx, memBe_r));
            end
            fetchIdx_nxt = RST_IDX;
            state_nxt    = S_FETCH;
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < REG_WORDS; i++) begin
        regs_r[i] <= RST_WORD;
      end
      state_r    <= S_IDLE;
      fetchIdx_r <= RST_IDX;
      dst_r      <= RST_WORD;
      lsAddr_r   <= RST_WORD;
      buf_r      <= RST_WORD;
      memReq_r   <= 1'b0;
      memAddr_r  <= RST_WORD;
      memWe_r    <= 1'b0;
      memIo_r    <= 1'b0;
      memBe_r    <= 4'h0;
      memWdata_r <= RST_WORD;
      flush_r    <= 1'b0;
      ill_r      <= 1'b0;
      run_r      <= 1'b0;
    end else begin
      regs_r     <= regsNxt;
      state_r    <= state_nxt;
      fetchIdx_r <= fetchIdx_nxt;
      dst_r      <= dst_nxt;
      lsAddr_r   <= lsAddr_nxt;
      buf_r      <= buf_nxt;
      memReq_r   <= memReq_nxt;
      memAddr_r  <= memAddr_nxt;
      memWe_r    <= memWe_nxt;
      memIo_r    <= memIo_nxt;
      memBe_r    <= memBe_nxt;
      memWdata_r <= memWdata_nxt;
      flush_r    <= flush_nxt;
      ill_r      <= ill_nxt;
      run_r      <= (state_nxt != S_IDLE);
    end
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign memReq        = memReq_r;
  assign memAddr       = memAddr_r;
  assign memWe         = memWe_r;
  assign memIo         = memIo_r;
  assign memBe         = memBe_r;
  assign memWdata      = memWdata_r;
  assign prefetchFlush = flush_r;
  assign illegalInstr  = ill_r;
  assign running       = run_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_fbr_host_lock: assert property (
    apbWrEn && wordIdx(paddr) == wordIdx(OFF_FBR) && !fbrLoad
    |=> fbr == $past(fbr))
    else $error("host write changed first byte received");
  a_jump_target: assert property (
    state_r == S_EXEC && cmd[31:27] == TYPE_JUMP && jumpTaken && !apbWrEn
    |=> state_r == S_FETCH ##1 memReq_r && memAddr_r == $past(opd, 2))
    else $error("taken jump did not fetch at target");
  a_fetch_step: assert property (
    state_r == S_FETCH && memReq_r && memAck && !apbWrEn
    |=> ip == $past(memAddr_r) + IP_STEP)
    else $error("pointer not advanced by four after fetch");
  a_move_align: assert property (
    state_r == S_EXEC && cmd[31:29] == TYPE_MOVE &&
    opd[1:0] != dst_r[1:0] |=> ill_r && state_r == S_IDLE)
    else $error("misaligned move not rejected");
  a_move_rsvd: assert property (
    state_r == S_EXEC && cmd[31:29] == TYPE_MOVE && cmd[28:25] != 4'h0
    |=> ill_r && !flush_r)
    else $error("reserved move bits not rejected");
  a_flush_gate: assert property (
    flush_r |-> $past(pfEn) && $past(state_r == S_EXEC))
    else $error("flush without prefetch enable");
  a_move_count: assert property (
    state_r == S_MVWR && memReq_r && memAck && !apbWrEn
    |=> cmd[23:0] == $past(cmd[23:0]) - {21'h0, $past(mvStep)})
    else $error("move count not decremented");
  a_ls_reladdr: assert property (
    state_r == S_EXEC && cmd[31:29] == TYPE_LS && cmd[LS_REL]
    |=> lsAddr_r == $past(relAddr))
    else $error("relative address wrong");
  a_ls_space: assert property (
    state_r == S_LSMEM && memReq_r && !memWe_r
    |-> memIo_r == regs_r[wordIdx(OFF_DMA_MODE_REGISTER)][DMA_MODE_REGISTER_SRC_IO])
    else $error("load used wrong space select");
  a_ls_own: assert property (
    state_r == S_LSMEM && memReq_r && memAck &&
    ownHit(lsAddr_r, regs_r[wordIdx(OFF_BASE)]) |=> ill_r && !run_r)
    else $error("own-space load or store not flagged");
  a_ls_fbrload: assert property (
    state_r == S_EXEC && cmd[31:29] == TYPE_LS && cmd[LS_LOAD] &&
    regIdx == wordIdx(OFF_FBR) |=> ill_r ##1 state_r == S_IDLE)
    else $error("load into first byte received accepted");
  a_ls_lanes: assert property (
    state_r == S_LSMEM && memReq_r |-> memBe_r == beMask(lsAddr_r[1:0],
                                                        cmd[2:0]))
    else $error("load or store lanes wrong");

endmodule

// File: bench/iml_mem_model.sv
// Memory and I/O space model answering the executor's bus cycles
`timescale 1ns/100ps
module iml_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  input  wire logic        memWe,
  input  wire logic [3:0]  memBe,
  input  wire logic [31:0] memWdata,
  output logic      [31:0] memRdata,
  output logic             memAck
);
  logic [31:0] mem [0:255];
  logic [1:0]  waitCnt = 2'h0;
  logic [1:0]  dly     = 2'h0;
  logic [31:0] lastD   = 32'h0;
  initial memAck = 1'b0;
  initial memRdata = 32'h0;
  // Latency rotates 0..3 cycles; read data is garbage outside the ack
  always @(posedge sys_clk) begin
    memAck <= 1'b0;
    memRdata <= ~lastD;
    if (memReq && !memAck) begin
      if (waitCnt == 2'h0) begin
        memAck <= 1'b1;
        memRdata <= mem[memAddr[9:2]];
        lastD <= mem[memAddr[9:2]];
        for (int b = 0; b < 4; b++)
          if (memWe && memBe[b])
            mem[memAddr[9:2]][8*b +: 8] <= memWdata[8*b +: 8];
        dly <= dly + 2'h1;
        waitCnt <= dly;
      end else
        waitCnt <= waitCnt - 2'h1;
    end
  end
endmodule

// File: bench/iml_move_load_store_test.sv
// Self-checking bench for the move, load and store executor
`timescale 1ns/100ps
module iml_move_load_store_test import iml_pkg::*;;
  logic        sys_clk = 0, sys_rst = 1, psel = 0, penable = 0;
  logic        pwrite = 0, fbrLoad = 0, phaseMatch = 0, err;
  logic [7:0]  paddr = 8'h00, fbrData = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, memAddr, memWdata, memRdata;
  logic        pready, pslverr, memReq, memWe, memIo, memAck;
  logic        prefetchFlush, illegalInstr, running;
  logic [3:0]  memBe;
  logic [31:0] seed = 1, q, sv, d0, d1, d2, d3;
  int          n_mismatch = 0, comparisons = 0, nWr = 0, badIo = 0;
  int          nFl = 0;
  // Software keeps each load/store inside one word
  logic [31:0] prog [0:19] = '{32'hE224_0004, 32'h200, 32'hE128_0004,
    32'h204, 32'hF12C_0004, 32'h00FF_FFFC, 32'hC000_0008, 32'h210,
    32'h220, 32'h800C_2085, 32'h40, 0, 0, 0, 0, 0, 32'hE024_0004,
    32'h230, 0, 0};
  logic [31:0] bad [0:11] = '{32'hC000_0004, 32'h211, 32'h220,
    32'hC200_0004, 32'h210, 32'h220, 32'hE11C_0001, 32'h204, 0,
    32'hE024_0004, 32'h8000_0024, 0};
  always #2.5 sys_clk = ~sys_clk;
  iml_move_load_store uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memReq(memReq), .memAddr(memAddr),
    .memWe(memWe), .memIo(memIo), .memBe(memBe), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .fbrLoad(fbrLoad),
    .fbrData(fbrData), .phaseMatch(phaseMatch),
    .prefetchFlush(prefetchFlush), .illegalInstr(illegalInstr),
    .running(running));
  iml_mem_model mdl (.sys_clk(sys_clk), .memReq(memReq),
    .memAddr(memAddr), .memWe(memWe), .memBe(memBe),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));
  always @(posedge sys_clk) begin
    if (memReq && memAck && memWe) begin
      nWr <= nWr + 1;
      if (memIo !== 1'b1) badIo <= badIo + 1;
    end
    if (prefetchFlush === 1'b1) nFl <= nFl + 1;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (i >= 40) begin
      n_mismatch++;
      results;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task run(input logic [31:0] ip);
    int i;
    apb(1'b1, OFF_IP, ip);
    repeat (3) @(posedge sys_clk);
    i = 0;
    while (running !== 1'b0 && i < 3000) begin
      @(posedge sys_clk);
      i++;
    end
    if (i >= 3000) begin
      n_mismatch++;
      results;
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk(32'({memReq, running, illegalInstr, prefetchFlush, pready}), 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, RST_WORD);
    end
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    $display("test reset done");
    sv = xs();
    d0 = xs();
    d1 = xs();
    d2 = xs();
    d3 = xs();
    for (int i = 0; i < 20; i++) mdl.mem[i] = prog[i];
    for (int i = 0; i < 12; i++) mdl.mem[32 + i / 3 * 4 + i % 3] = bad[i];
    mdl.mem[129] = d0;
    mdl.mem[191] = d1;
    mdl.mem[132] = d2;
    mdl.mem[133] = d3;
    apb(1'b1, OFF_BASE, 32'h8000_0000);
    apb(1'b1, 8'h24, sv);
    apb(1'b1, OFF_DSB, 32'h300);
    apb(1'b1, OFF_DMA_MODE_REGISTER, 32'h10);
    apb(1'b1, OFF_DMA_CONTROL_REGISTER, 32'h20);
    fbrLoad <= 1'b1;
    fbrData <= 8'hA5;
    @(posedge sys_clk);
    fbrLoad <= 1'b0;
    apb(1'b1, OFF_FBR, 32'hFFFF_FFFF);
    apb(1'b0, OFF_FBR, 32'h0);
    chk({24'h0, q[7:0]}, 32'hA5);
    run(32'h0);
    chk(mdl.mem[128], sv);
    apb(1'b0, 8'h28, 32'h0);
    chk(q, d0);
    apb(1'b0, 8'h2C, 32'h0);
    chk(q, d1);
    chk(mdl.mem[136], d2);
    chk(mdl.mem[137], d3);
    apb(1'b0, OFF_DSB, 32'h0);
    chk(q, 32'h300);
    chk(mdl.mem[140], sv);
    chk(nWr, 4);
    chk(badIo, 0);
    chk(nFl, 2);
    $display("test program done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_STAT, 32'h1);
      @(posedge sys_clk);
      chk({31'h0, illegalInstr}, 32'h0);
      run(32'h80 + 32'(i * 16));
      chk({31'h0, illegalInstr}, 32'h1);
      chk(mdl.mem[136], d2);
      chk(nWr, (i == 3) ? 5 : 4);
      $display("test illegal %0d done", i);
    end
    // Jump needing data and phase true, then own-register move
    mdl.mem[48] = 32'h800E_2085;
    mdl.mem[49] = 32'h40;
    mdl.mem[50] = 32'hC100_0004;
    mdl.mem[51] = 32'h8000_0024;
    mdl.mem[52] = 32'h260;
    mdl.mem[53] = 32'h0;
    mdl.mem[54] = 32'h0;
    run(32'hC0);
    chk(mdl.mem[152], sv);
    chk(nWr, 6);
    chk(nFl, 3);
    mdl.mem[152] = 32'h0;
    phaseMatch <= 1'b1;
    run(32'hC0);
    chk(mdl.mem[152], 32'h0);
    chk(nWr, 7);
    chk(nFl, 4);
    $display("test polarity done");
    apb(1'b0, OFF_FBR, 32'h0);
    chk({24'h0, q[7:0]}, 32'hA5);
    results;
  end
endmodule
